/* rtl/tmr8_pkg.sv */
// Shared constants and types of the 8-bit timer wave control block
package tmr8_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_A_OFS  = 8'h24; // Output modes, low wave bits
  localparam logic [7:0] CTRL_B_OFS  = 8'h25; // Wave mode high bit
  localparam logic [7:0] STATUS_OFS  = 8'h30; // Live output and mode state
  localparam logic [7:0] CTRL_A_RST  = 8'h00; // Control A after reset
  localparam logic [7:0] CTRL_A_WMSK = 8'hf3; // Bits 3:2 never store

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OUT_A_POS   = 6; // out_a_mode[1:0]
  localparam int OUT_B_POS   = 4; // out_b_mode[1:0]
  localparam int WAVE_LO_POS = 0; // wave_mode_low_bits[1:0]
  localparam int WAVE_HI_POS = 3; // wave_mode_high_bit in control B
  localparam int ST_OUTA_POS = 0; // Status: compare_out_a
  localparam int ST_OUTB_POS = 1; // Status: compare_out_b
  localparam int ST_RSVD_POS = 2; // Status: reserved mode selected
  localparam int ST_DUAL_POS = 3; // Status: dual-slope sequence

  // ----------------------------------------------------------------
  // Count values
  // ----------------------------------------------------------------
  localparam logic [7:0] CNT_MAX    = 8'hff; // MAX and fixed TOP
  localparam logic [7:0] CNT_BOTTOM = 8'h00; // BOTTOM

  // ----------------------------------------------------------------
  // Wave mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] WM_NORMAL  = 3'h0;
  localparam logic [2:0] WM_PC_FF   = 3'h1;
  localparam logic [2:0] WM_CLR     = 3'h2;
  localparam logic [2:0] WM_FAST_FF = 3'h3;
  localparam logic [2:0] WM_RSV4    = 3'h4;
  localparam logic [2:0] WM_PC_A    = 3'h5;
  localparam logic [2:0] WM_RSV6    = 3'h6;
  localparam logic [2:0] WM_FAST_A  = 3'h7;

  // Waveform class of a mode
  typedef enum logic [3:0] {
    CLS_NONPWM = 4'b0001,
    CLS_FAST   = 4'b0010,
    CLS_PHASE  = 4'b0100,
    CLS_RSVD   = 4'b1000
  } tmr8_cls_t;

  // Point in the count sequence
  typedef enum logic [3:0] {
    PT_IMM = 4'b0001,
    PT_MAX = 4'b0010,
    PT_BOT = 4'b0100,
    PT_TOP = 4'b1000
  } tmr8_pt_t;

endpackage : tmr8_pkg

/* rtl/tmr8_chan_if.sv */
// Carrier between the wave control and one compare output channel
`timescale 1ns/10ps
`default_nettype none
interface tmr8_chan_if;
  import tmr8_pkg::*;
  logic [1:0] code;    // Channel output mode code
  tmr8_cls_t  cls;     // Waveform class
  logic       is_a;    // Channel A has the toggle option
  logic       hi_bit;  // wave_mode_high_bit
  logic       match;   // Compare match this tick
  logic       eq_top;  // Compare value equals TOP
  logic       at_bot;  // Tick with count at BOTTOM
  logic       at_top;  // Tick with count at TOP
  logic       down;    // Counting down
  logic       out;     // Registered compare output
  modport ctrl (output code, cls, is_a, hi_bit, match, eq_top, at_bot, at_top, down, input out);
  modport chan (input code, cls, is_a, hi_bit, match, eq_top, at_bot, at_top, down, output out);
endinterface : tmr8_chan_if
`default_nettype wire

/* rtl/tmr8_chan.sv */
// One compare output channel: applies the mode code to its output
`timescale 1ns/10ps
`default_nettype none
module tmr8_chan
  import tmr8_pkg::*;
(
  // Clock and reset
  input  wire logic   core_clk_i,
  input  wire logic   arst_n_i,
  // Control side
  tmr8_chan_if.chan   ch
);

  logic out_q; // Output level
  logic out_d; // Next output level
  logic ign;   // Match on TOP is ignored

  assign ign    = ch.eq_top & ch.code[1];
  assign ch.out = out_q;

  // ----------------------------------------------------------------
  // Next output level
  // ----------------------------------------------------------------
  always_comb begin
    out_d = out_q;
    unique case (ch.cls)
      CLS_NONPWM: begin
        // Match acts by the code; 00 leaves it alone
        if (ch.match) begin
          unique case (ch.code)
            2'b01:   out_d = ~out_q;
            2'b10:   out_d = 1'b0;
            2'b11:   out_d = 1'b1;
            default: out_d = out_q;
          endcase
        end
      end
      CLS_FAST: begin
        // BOTTOM first so a same-tick match has the last word
        if (ch.at_bot && ch.code[1]) begin
          out_d = ~ch.code[0];
        end
        // Channel B with match ignored acts at TOP
        if (!ch.is_a && ign && ch.at_top) begin
          out_d = ~ch.code[0];
        end
        if (ch.match && !ign) begin
          if (ch.code[1]) begin
            out_d = ch.code[0];
          end else if (ch.code[0] && ch.is_a && ch.hi_bit) begin
            out_d = ~out_q;
          end
        end
      end
      CLS_PHASE: begin
        if (ign && ch.at_top) begin
          out_d = ~ch.code[0];
        end else if (ch.match && !ign) begin
          if (ch.code[1]) begin
            // Up: code bit 0; down: its inverse
            out_d = ch.code[0] ^ ch.down;
          end else if (ch.code[0] && ch.is_a && ch.hi_bit) begin
            out_d = ~out_q;
          end
        end
      end
      CLS_RSVD: out_d = out_q; // Reserved mode: hold
    endcase
  end

  // Output register
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_q <= 1'b0;
    end else begin
      out_q <= out_d;
    end
  end

endmodule : tmr8_chan
`default_nettype wire

/* rtl/tmr8_wave_ctrl.sv */
// Wave mode decode, control registers and compare outputs of an 8-bit timer
// ------------------------------------------------------------------
// ------------------------------------------------------------------
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module tmr8_wave_ctrl
  import tmr8_pkg::*;
#(
  parameter int ADDR_W = 8 // Register address width
)(
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              arst_n_i,
  // Register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [7:0]        rdata_o,
  // Counter side, same clock
  input  wire logic              tick_i,
  input  wire logic [7:0]        count_value_i,
  input  wire logic              count_down_i,
  input  wire logic [7:0]        compare_value_a_i,
  input  wire logic [7:0]        compare_value_b_i,
  // Decoded sequence
  output logic [7:0]             top_value_o,
  output logic                   dual_slope_o,
  output logic                   ovf_pulse_o,
  output logic                   cmp_upd_o,
  // Pins
  output logic                   compare_out_a_o,
  output logic                   compare_out_b_o,
  output logic                   pin_take_a_o,
  output logic                   pin_take_b_o
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // Offsets reach 0x30, so six address bits at least
  if (ADDR_W < 6) begin : g_bad_addr
    $error("ADDR_W too small for the register map");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] ctl_a_q;     // Control A
  logic       wave_hi_q;   // wave_mode_high_bit
  logic [7:0] rdata_q;     // Read data
  logic [2:0] wave_mode;   // Combined mode code
  tmr8_cls_t  cls;         // Waveform class
  tmr8_pt_t   upd_pt;      // Compare update point
  tmr8_pt_t   ovf_pt;      // overflow_flag point
  logic       top_from_a;  // TOP is compare_value_a
  logic [7:0] top_d;       // Current TOP
  logic       at_bot;      // Tick at BOTTOM
  logic       at_top;      // Tick at TOP
  logic       at_max;      // Tick at MAX
  logic       ovf_d;       // Overflow event
  logic       upd_d;       // Update event
  logic [1:0] code [2];    // Per-channel mode codes
  logic [7:0] cmpv [2];    // Per-channel compare values
  logic       ch_out [2];  // Per-channel outputs
  logic       pin_a_q;     // Pin takeover A
  logic       pin_b_q;     // Pin takeover B

  tmr8_chan_if ch_if [2] (); // Channel carriers

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Control A; reserved bits never store, so they read zero
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctl_a_q <= CTRL_A_RST;
    end else if (wr_i && addr_i == ADDR_W'(CTRL_A_OFS)) begin
      ctl_a_q <= wdata_i & CTRL_A_WMSK;
    end
  end

  // Control B: only the high wave bit lives in this block
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wave_hi_q <= 1'b0;
    end else if (wr_i && addr_i == ADDR_W'(CTRL_B_OFS)) begin
      wave_hi_q <= wdata_i[WAVE_HI_POS];
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Data stand in the cycle after the strobe only
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= 8'h00;
    end else if (!rd_i) begin
      rdata_q <= 8'h00;
    end else begin
      unique case (addr_i)
        ADDR_W'(CTRL_A_OFS): rdata_q <= ctl_a_q;
        ADDR_W'(CTRL_B_OFS): rdata_q <= 8'(wave_hi_q) << WAVE_HI_POS;
        ADDR_W'(STATUS_OFS): begin
          rdata_q              <= 8'h00;
          rdata_q[ST_OUTA_POS] <= ch_out[0];
          rdata_q[ST_OUTB_POS] <= ch_out[1];
          rdata_q[ST_RSVD_POS] <= (cls == CLS_RSVD);
          rdata_q[ST_DUAL_POS] <= (cls == CLS_PHASE);
        end
        default: rdata_q <= 8'h00; // Unmapped reads zero
      endcase
    end
  end

  assign rdata_o = rdata_q;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // High bit from control B, low bits from control A
  assign wave_mode = {wave_hi_q, ctl_a_q[WAVE_LO_POS +: 2]};

  // Every code is listed, so no default is needed
  always_comb begin
    cls        = CLS_RSVD;
    upd_pt     = PT_IMM;
    ovf_pt     = PT_MAX;
    top_from_a = 1'b0;
    unique case (wave_mode)
      WM_NORMAL: begin
        cls    = CLS_NONPWM;
        upd_pt = PT_IMM;
        ovf_pt = PT_MAX;
      end
      WM_PC_FF: begin
        cls    = CLS_PHASE;
        upd_pt = PT_TOP;
        ovf_pt = PT_BOT;
      end
      WM_CLR: begin
        cls        = CLS_NONPWM;
        top_from_a = 1'b1;
        upd_pt     = PT_IMM;
        ovf_pt     = PT_MAX;
      end
      WM_FAST_FF: begin
        cls    = CLS_FAST;
        upd_pt = PT_BOT;
        ovf_pt = PT_MAX;
      end
      WM_PC_A: begin
        cls        = CLS_PHASE;
        top_from_a = 1'b1;
        upd_pt     = PT_TOP;
        ovf_pt     = PT_BOT;
      end
      WM_FAST_A: begin
        cls        = CLS_FAST;
        top_from_a = 1'b1;
        upd_pt     = PT_BOT;
        ovf_pt     = PT_TOP;
      end
      // Reserved codes define nothing: no flag, no update
      WM_RSV4, WM_RSV6: begin
        cls = CLS_RSVD;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequence points
  // ----------------------------------------------------------------
  assign top_d  = top_from_a ? compare_value_a_i : CNT_MAX;
  assign at_bot = tick_i && count_value_i == CNT_BOTTOM;
  assign at_top = tick_i && count_value_i == top_d;
  assign at_max = tick_i && count_value_i == CNT_MAX;

  // Overflow point per mode; reserved modes never flag
  always_comb begin
    ovf_d = 1'b0;
    if (cls != CLS_RSVD) begin
      unique case (ovf_pt)
        PT_MAX:  ovf_d = at_max;
        PT_BOT:  ovf_d = at_bot;
        PT_TOP:  ovf_d = at_top;
        PT_IMM:  ovf_d = 1'b0;
      endcase
    end
  end

  // Compare update point; immediate means every cycle
  always_comb begin
    upd_d = 1'b0;
    if (cls != CLS_RSVD) begin
      unique case (upd_pt)
        PT_IMM:  upd_d = 1'b1;
        PT_TOP:  upd_d = at_top;
        PT_BOT:  upd_d = at_bot;
        PT_MAX:  upd_d = 1'b0;
      endcase
    end
  end

  // Registered sequence outputs
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      top_value_o  <= CNT_MAX;
      dual_slope_o <= 1'b0;
      ovf_pulse_o  <= 1'b0;
      cmp_upd_o    <= 1'b0;
    end else begin
      top_value_o  <= top_d;
      dual_slope_o <= (cls == CLS_PHASE);
      ovf_pulse_o  <= ovf_d;
      cmp_upd_o    <= upd_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin takeover
  // ----------------------------------------------------------------
  // Any nonzero code hands the pin to the channel
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b0;
    end else begin
      pin_a_q <= |ctl_a_q[OUT_A_POS +: 2];
      pin_b_q <= |ctl_a_q[OUT_B_POS +: 2];
    end
  end

  // The driver still needs the port direction set outside
  assign pin_take_a_o = pin_a_q;
  assign pin_take_b_o = pin_b_q;

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  assign code[0] = ctl_a_q[OUT_A_POS +: 2];
  assign code[1] = ctl_a_q[OUT_B_POS +: 2];
  assign cmpv[0] = compare_value_a_i;
  assign cmpv[1] = compare_value_b_i;

  for (genvar i = 0; i < 2; i++) begin : g_chan
    assign ch_if[i].code   = code[i];
    assign ch_if[i].cls    = cls;
    assign ch_if[i].is_a   = (i == 0);
    assign ch_if[i].hi_bit = wave_hi_q;
    assign ch_if[i].match  = tick_i && count_value_i == cmpv[i];
    assign ch_if[i].eq_top = cmpv[i] == top_d;
    assign ch_if[i].at_bot = at_bot;
    assign ch_if[i].at_top = at_top;
    assign ch_if[i].down   = count_down_i;
    assign ch_out[i]       = ch_if[i].out;

    tmr8_chan u_chan (
      .core_clk_i (core_clk_i),
      .arst_n_i   (arst_n_i),
      .ch         (ch_if[i])
    );
  end

  // Both outputs are the channel flops themselves
  assign compare_out_a_o = ch_out[0];
  assign compare_out_b_o = ch_out[1];
  // Pins only ever see registered levels, never the raw decode

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_rd_a;
    rd_i && addr_i == ADDR_W'(CTRL_A_OFS);
  endsequence

  sequence s_wr_b;
    wr_i && addr_i == ADDR_W'(CTRL_B_OFS);
  endsequence

  rsvd_bits_a: assert property (s_rd_a |=> rdata_o[3:2] == 2'b00)
    else $error("reserved control bits read nonzero");

  mode_high_a: assert property (s_wr_b ##1 !wr_i |=> wave_mode[2] == $past(wdata_i[WAVE_HI_POS], 2))
    else $error("high wave bit not taken from control B");

  pin_take_a: assert property (##1 pin_take_a_o == |$past(ctl_a_q[OUT_A_POS +: 2]))
    else $error("pin takeover A does not follow code");

  top_fixed_a: assert property (wave_mode == WM_NORMAL |=> top_value_o == CNT_MAX)
    else $error("normal mode TOP not 0xFF");

  top_cmp_a: assert property (wave_mode == WM_CLR |=> top_value_o == $past(compare_value_a_i))
    else $error("clear-on-match TOP not compare A");

  ovf_phase_a: assert property (wave_mode == WM_PC_A && tick_i && count_value_i == CNT_BOTTOM
                                |=> ovf_pulse_o)
    else $error("phase mode overflow missing at BOTTOM");

  ovf_fast_a: assert property (wave_mode == WM_FAST_A && tick_i && count_value_i != top_d
                               |=> !ovf_pulse_o)
    else $error("fast mode 7 overflow away from TOP");

  upd_fast_a: assert property (wave_mode == WM_FAST_FF |=> cmp_upd_o == $past(at_bot))
    else $error("fast mode update not at BOTTOM");

  toggle_out_a: assert property (cls == CLS_NONPWM && code[0] == 2'b01 && ch_if[0].match
                                 |=> compare_out_a_o != $past(compare_out_a_o))
    else $error("non-PWM toggle did not toggle");

  fast_set_a: assert property (cls == CLS_FAST && code[1] == 2'b10 && at_bot && !ch_if[1].match
                               |=> compare_out_b_o)
    else $error("fast PWM B not set at BOTTOM");

  phase_clr_a: assert property (cls == CLS_PHASE && code[0] == 2'b10 && ch_if[0].match
                                && !ch_if[0].eq_top && !count_down_i |=> !compare_out_a_o)
    else $error("phase PWM A not cleared on up match");

  rsvd_hold_a: assert property (cls == CLS_RSVD ##1 cls == CLS_RSVD |-> $stable(compare_out_a_o)
                                && !ovf_pulse_o)
    else $error("reserved mode changed output or flagged");

endmodule : tmr8_wave_ctrl
`default_nettype wire

/* testbench/tmr8_pin_model.sv */
// Port pin model: compare output or the pulled-up port input
`timescale 1ns/10ps
`default_nettype none
module tmr8_pin_model (
  // Pin control from the block
  input  wire logic take_i,  // Channel owns the pin
  input  wire logic wave_i,  // Compare output level
  // Software port setup
  input  wire logic dir_i,   // Direction bit, 1 = output
  // Pad
  output logic      pin_o    // Level seen at the pad
);
  // ----------------------------------------------------------------
  // Pad level
  // ----------------------------------------------------------------
  // Driver off leaves only the pull-up, so the wave never reaches the pad
  assign pin_o = (take_i && dir_i) ? wave_i : 1'b1;
endmodule : tmr8_pin_model
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench of the 8-bit timer wave control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import tmr8_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        core_clk_i = 1'b0, arst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic        tick_i = 1'b0, count_down_i = 1'b0;
  logic [7:0]  addr_i = 8'h00, wdata_i = 8'h00, count_value_i = 8'h00;
  logic [7:0]  cva = 8'h00, cvb = 8'h00;         // Compare values
  logic [7:0]  rdata_o, top_value_o;
  logic        dual_slope_o, ovf_pulse_o, cmp_upd_o, out_a, out_b, take_a, take_b;
  logic        dir_a = 1'b1, dir_b = 1'b1;       // Port set to output
  logic        pin_a, pin_b;                     // Pad levels
  int          num_errors = 0, n_checks = 0, cyc = 0;
  logic [7:0]  rq[$];                            // Expected read data
  logic [14:0] tq[$];                            // Expected tick results
  logic        rd_p = 1'b0, tk_p = 1'b0;         // A result is due
  // Reference state, updated as the bench writes
  logic [2:0]  mode = 3'h0;
  logic [1:0]  ca = 2'h0, cb = 2'h0;
  logic        ma = 1'b0, mb = 1'b0;
  logic [7:0]  ka, kb;
  // The mode loop avoids reserved modes 4 and 6
  logic [2:0]  ml[6] = '{WM_NORMAL, WM_PC_FF, WM_CLR, WM_FAST_FF, WM_PC_A, WM_FAST_A};

  // ----------------------------------------------------------------
  // Design and pads
  // ----------------------------------------------------------------
  tmr8_wave_ctrl u_tmr8_wave_ctrl (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tick_i(tick_i),
    .count_value_i(count_value_i), .count_down_i(count_down_i), .compare_value_a_i(cva),
    .compare_value_b_i(cvb), .top_value_o(top_value_o), .dual_slope_o(dual_slope_o),
    .ovf_pulse_o(ovf_pulse_o), .cmp_upd_o(cmp_upd_o), .compare_out_a_o(out_a),
    .compare_out_b_o(out_b), .pin_take_a_o(take_a), .pin_take_b_o(take_b));
  tmr8_pin_model u_pin_a (.take_i(take_a), .wave_i(out_a), .dir_i(dir_a), .pin_o(pin_a));
  tmr8_pin_model u_pin_b (.take_i(take_b), .wave_i(out_b), .dir_i(dir_b), .pin_o(pin_b));

  // Clock of 4 ns
  initial begin
    forever #2 core_clk_i = ~core_clk_i;
  end

  // Watchdog: the whole run needs well under this many cycles
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Compare and verdict
  // ----------------------------------------------------------------
  task automatic cmp_rd(input logic [7:0] e);
    n_checks++;
    if (rdata_o !== e) begin
      num_errors++;
      $display("[FAIL] rdata_o expected %h seen %h", e, rdata_o);
    end
  endtask : cmp_rd

  task automatic cmp_tk(input logic [14:0] e);
    logic [14:0] s;
    s = {top_value_o, dual_slope_o, cmp_upd_o, ovf_pulse_o, take_b, take_a, pin_b, pin_a};
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] top/dual/upd/ovf/take/pin expected %h seen %h", e, s);
    end
  endtask : cmp_tk

  task automatic conclude();
    if (num_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // Register bus: one strobe cycle, then an idle edge
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    wr_i    <= w;
    rd_i    <= !w;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask : bus

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    if (a == CTRL_A_OFS) {ca, cb, mode[1:0]} = {d[7:4], d[1:0]};
    if (a == CTRL_B_OFS) mode[2] = d[3];
    bus(1'b1, a, d);
  endtask : wreg

  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask : rreg

  // ----------------------------------------------------------------
  // Reference of one channel for one tick
  // ----------------------------------------------------------------
  function automatic logic chan(input logic [1:0] cd, input logic isa, input logic pv, input logic m,
                                input logic et, input logic b, input logic t, input logic dn);
    logic r;
    r = pv;
    // Reserved modes 4 and 6: output holds
    if (mode[2] && !mode[0]) return pv;
    if (!mode[0]) begin
      // Non-PWM: toggle, clear, set on match
      if (m && cd != 2'h0) r = (cd == 2'h1) ? !pv : cd[0];
    end else if (cd == 2'h1) begin
      // Toggle only on channel A with the high bit
      if (isa && mode[2] && m) r = !pv;
    end else if (cd[1] && mode[1]) begin
      // Fast: BOTTOM action first, a match wins
      if (b) r = !cd[0];
      if (m && !et) r = cd[0];
      if (et && t && !isa) r = !cd[0];
    end else if (cd[1]) begin
      // Phase: the match action flips with direction
      if (m && !et) r = cd[0] ^ dn;
      if (et && t) r = !cd[0];
    end
    return r;
  endfunction : chan

  task automatic tick(input logic [7:0] c, input logic dn);
    logic [7:0] top;
    logic       bt, at, ovf, upd, ph, rs;
    top = (mode inside {WM_CLR, WM_PC_A, WM_FAST_A}) ? ka : CNT_MAX;
    ph  = !mode[1] && mode[0];
    rs  = mode[2] && !mode[0];
    bt  = (c == CNT_BOTTOM);
    at  = (c == top);
    ovf = rs ? 1'b0 : ph ? bt : (mode == WM_FAST_A) ? at : (c == CNT_MAX);
    upd = rs ? 1'b0 : ph ? at : mode[0] ? bt : 1'b1;
    ma  = chan(ca, 1'b1, ma, c == ka, ka == top, bt, at, dn);
    mb  = chan(cb, 1'b0, mb, c == kb, kb == top, bt, at, dn);
    tq.push_back({top, ph, upd, ovf, |cb, |ca, (|cb && dir_b) ? mb : 1'b1, (|ca && dir_a) ? ma : 1'b1});
    @(posedge core_clk_i);
    tick_i        <= 1'b1;
    count_value_i <= c;
    count_down_i  <= dn;
    @(posedge core_clk_i);
    tick_i <= 1'b0;
  endtask : tick

  // ----------------------------------------------------------------
  // Monitor: results are sampled mid-cycle, clear of the edge
  // ----------------------------------------------------------------
  always @(negedge core_clk_i) begin
    if (rd_p && rq.size() > 0) cmp_rd(rq.pop_front());
    if (tk_p && tq.size() > 0) cmp_tk(tq.pop_front());
    rd_p = rd_i;
    tk_p = tick_i;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(59));
    repeat (5) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    rreg(CTRL_A_OFS, CTRL_A_RST);
    rreg(CTRL_B_OFS, 8'h00);
    wreg(CTRL_A_OFS, 8'hff);
    wreg(8'h26, 8'h00);
    rreg(CTRL_A_OFS, 8'hf3);
    wreg(CTRL_B_OFS, 8'hff);
    rreg(CTRL_B_OFS, 8'h08);
    rreg(8'h26, 8'h00);
    // Pass 0 random compare values, pass 1 both at MAX for the TOP cases
    for (int p = 0; p < 2; p++) begin
      @(posedge core_clk_i);
      ka = p ? CNT_MAX : 8'($urandom_range(254, 129));
      kb = p ? CNT_MAX : ka - 8'h7f;
      cva <= ka;
      cvb <= kb;
      foreach (ml[i]) begin
        for (int k = 0; k < 4; k++) begin
          wreg(CTRL_B_OFS, {4'h0, ml[i][2], 3'h0});
          wreg(CTRL_A_OFS, {k[1:0], k[1:0], 2'h0, ml[i][1:0]});
          // Up to TOP, hold, then down to BOTTOM
          tick(CNT_BOTTOM, 1'b0);
          tick(kb, 1'b0);
          tick(ka, 1'b0);
          tick(mode[2] || mode == WM_CLR ? ka : CNT_MAX, 1'b0);
          tick(ka, 1'b1);
          tick(kb, 1'b1);
          tick(CNT_BOTTOM, 1'b1);
        end
        // Status shows the dual-slope class of the mode just run
        rreg(STATUS_OFS, {4'h0, !mode[1] && mode[0], 1'b0, mb, ma});
      end
    end
    rreg(STATUS_OFS, {4'h0, 1'b0, 1'b0, mb, ma});
    // Reserved mode 4: outputs hold, no flag, no update; port A left as input
    wreg(CTRL_B_OFS, 8'h08);
    wreg(CTRL_A_OFS, 8'hf0);
    dir_a = 1'b0;
    tick(CNT_MAX, 1'b0);
    tick(CNT_BOTTOM, 1'b0);
    rreg(STATUS_OFS, {4'h0, 1'b0, 1'b1, mb, ma});
    repeat (3) @(posedge core_clk_i);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
